// ---- hw/pmm_map_top.sv ----
/*
 program memory map: counter and vectors, fetch address wrap, region tags,
 indirect reads of program memory, identity words and partition setting over APB.
 assumes a core on clk_sys that drives advance/load/interrupt pulses and honours dataStall,
 and a two-port program memory (fetch port and data port) outside this block.
*/
// Notes on behaviour
// - identity word: part code, bits 13:12 ones
// - revision word read-only, bits 13:12 are 10
// - revision bits 11:6 major stepping
// - revision bits 5:0 minor stepping
// - fifteen-bit counter over 32K word space
// - addresses above 3FFFh wrap into flash
// - reset starts at 0000h, interrupt at 0004h
// - pointer bit 7 reads low program byte
// - indirect writes never change program memory
// - indirect program read adds two stall cycles
// - fetch and data ports are separate buses
// - EEPROM not mapped into data space
// - flash split into application, boot, storage
// - erased defaults give all application
// - boot region starts at zero when enabled
// - size codes 111/110/101 end 01FF/03FF/07FF
// - boot region clamped to half flash
// - storage last 128 words, not executable
`timescale 1ns/100ps
module pmm_map_top
    import pmm_pkg::*;
#(
    parameter logic [11:0] PART_CODE  = 12'h0A5,  // arbitrary value
    parameter logic [5:0]  MAJOR_STEP = 6'h01,    // arbitrary value
    parameter logic [5:0]  MINOR_STEP = 6'h00     // arbitrary value
)
(
    input  wire logic              clk_sys,
    input  wire logic              srst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [APB_AW-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              coreAdvance,
    input  wire logic              coreLoad,
    input  wire logic [PC_W-1:0]   coreLoadAddr,
    input  wire logic              irqTake,
    output logic [PC_W-1:0]        pcValue,
    output logic [MEM_AW-1:0]      fetchAddr,
    output logic [1:0]             fetchRegion,
    output logic                   execViolation,
    input  wire logic              dataReq,
    input  wire logic              dataWrite,
    input  wire logic [7:0]        indirectPointerHigh,
    input  wire logic [7:0]        indirectPointerLow,
    output logic [MEM_AW-1:0]      dataMemAddr,
    input  wire logic [WORD_W-1:0] dataMemRdata,
    output logic [7:0]             indirectDataPort,
    output logic                   dataDone,
    output logic                   dataStall,
    output logic                   writeDropped
);
    logic [PC_W-1:0]   pc_q, pc_d;
    logic [1:0]        region_q, region_d;
    logic              viol_q, viol_d;
    logic [PART_W-1:0] part_q, part_d;
    logic [31:0]       rdata_q, rdata_d;
    logic              ready_q, ready_d;
    logic              err_q, err_d;
    logic [31:0]       rdMux;
    logic              mapped;
    logic [15:0]       regIdx;
    logic              access;
    pmm_region_type    nextRegion;
    logic [MEM_AW-1:0] bootEnd;
    logic [MEM_AW-1:0] pcWrapped;
    logic [15:0]       identWord;
    logic [15:0]       revWord;

    // identity words, constant
    assign identWord = {2'b00, IDENT_TOP_BITS, PART_CODE};
    assign revWord   = {2'b00, REV_TOP_BITS, MAJOR_STEP, MINOR_STEP};

    // program counter and vectors
    always_comb begin
        pc_d = pc_q;
        if (irqTake) begin
            pc_d = IRQ_VECTOR;
        end else if (coreLoad) begin
            pc_d = coreLoadAddr;
        end else if (coreAdvance && !dataStall) begin
            pc_d = PC_W'(pc_q + 15'h0001);
        end
    end

    assign pcWrapped = pc_d[MEM_AW-1:0];

    pmm_partition u_partition (
        .partCfg (part_q),
        .addr    (pcWrapped),
        .region  (nextRegion),
        .bootEnd (bootEnd)
    );

    // fetch-side tags for the address being issued
    always_comb begin
        region_d = nextRegion;
        viol_d   = (nextRegion == PMM_REG_STORE);
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pc_q     <= RESET_VECTOR;
            region_q <= 2'b00;
            viol_q   <= 1'b0;
        end else begin
            pc_q     <= pc_d;
            region_q <= region_d;
            viol_q   <= viol_d;
        end
    end

    assign pcValue       = pc_q;
    assign fetchAddr     = pc_q[MEM_AW-1:0];
    assign fetchRegion   = region_q;
    assign execViolation = viol_q;

    // data-side port, independent of fetch; eeprom is never decoded here
    pmm_indirect u_indirect (
        .clk_sys      (clk_sys),
        .srst         (srst),
        .reqValid     (dataReq),
        .reqWrite     (dataWrite),
        .ptrHigh      (indirectPointerHigh),
        .ptrLow       (indirectPointerLow),
        .memRdata     (dataMemRdata),
        .memAddr      (dataMemAddr),
        .stall        (dataStall),
        .rdata        (indirectDataPort),
        .done         (dataDone),
        .writeDropped (writeDropped)
    );

    // APB slave, one wait state
    assign regIdx = 16'(paddr[APB_AW-1:2]);
    assign access = psel && penable;

    always_comb begin
        mapped = 1'b1;
        case (regIdx)
            IDX_REVISION:  rdMux = {16'h0000, revWord};
            IDX_IDENTITY:  rdMux = {16'h0000, identWord};
            IDX_PARTITION: rdMux = {27'h0000000, part_q};
            IDX_STATUS:    rdMux = {bootEnd, region_q, viol_q, pc_q};
            default: begin
                rdMux  = 32'h00000000;
                mapped = 1'b0;
            end
        endcase
        if (paddr[1:0] != 2'b00) begin
            mapped = 1'b0;
        end
    end

    always_comb begin
        ready_d = 1'b0;
        rdata_d = rdata_q;
        err_d   = 1'b0;
        part_d  = part_q;
        if (access && !ready_q) begin
            ready_d = 1'b1;
            err_d   = !mapped;
            rdata_d = (pwrite || !mapped) ? 32'h00000000 : rdMux;
        end
        if (access && ready_q && pwrite && mapped && regIdx == IDX_PARTITION) begin
            part_d = pwdata[PART_W-1:0];
        end
        // identity and revision writes fall through unchanged
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ready_q <= 1'b0;
            rdata_q <= 32'h00000000;
            err_q   <= 1'b0;
            part_q  <= PART_RESET;
        end else begin
            ready_q <= ready_d;
            rdata_q <= rdata_d;
            err_q   <= err_d;
            part_q  <= part_d;
        end
    end

    assign prdata  = rdata_q;
    assign pready  = ready_q;
    assign pslverr = err_q;
endmodule

// ---- pkg/pmm_pkg.sv ----
/*
 package for the program memory map and identity block.
 assumes a 14-bit word program memory behind a 15-bit counter and an APB register port.
*/
package pmm_pkg;
    localparam int          PC_W           = 15;
    localparam int          MEM_AW         = 14;
    localparam int          WORD_W         = 14;
    localparam int          APB_AW         = 18;
    // register indices; byte address is four times the index
    localparam logic [15:0] IDX_REVISION   = 16'h8005;
    localparam logic [15:0] IDX_IDENTITY   = 16'h8006;
    localparam logic [15:0] IDX_PARTITION  = 16'h800A;
    localparam logic [15:0] IDX_STATUS     = 16'h8010;
    // identity word layout
    localparam logic [1:0]  IDENT_TOP_BITS = 2'b11;
    localparam logic [1:0]  REV_TOP_BITS   = 2'b10;
    // partition register: bit 4 storage enable_n, bit 3 boot enable_n, bits 2:0 size
    localparam int          PART_W         = 5;
    localparam int          PART_STOR_BIT  = 4;
    localparam int          PART_BOOT_BIT  = 3;
    localparam logic [4:0]  PART_RESET     = 5'h1F;
    // vectors and map limits
    localparam logic [14:0] RESET_VECTOR   = 15'h0000;
    localparam logic [14:0] IRQ_VECTOR     = 15'h0004;
    localparam logic [13:0] LAST_ADDR      = 14'h3FFF;
    localparam logic [13:0] HALF_END       = 14'h1FFF;
    localparam logic [13:0] STORAGE_WORDS  = 14'h0080;
    localparam logic [13:0] BOOT_END_111   = 14'h01FF;
    localparam logic [13:0] BOOT_END_110   = 14'h03FF;
    localparam logic [13:0] BOOT_END_101   = 14'h07FF;
    localparam logic [13:0] BOOT_END_100   = 14'h0FFF;
    localparam logic [13:0] BOOT_END_011   = 14'h1FFF;
    localparam int          PTR_PROG_BIT   = 7;
    typedef enum logic [1:0] {
        PMM_REG_APP,
        PMM_REG_BOOT,
        PMM_REG_STORE
    } pmm_region_type;
endpackage

// ---- hw/pmm_partition.sv ----
/*
 combinational decode of an address into application, boot or storage region.
 assumes the partition settings are steady while read.
*/
`timescale 1ns/100ps
module pmm_partition
    import pmm_pkg::*;
(
    input  wire logic [PART_W-1:0] partCfg,
    input  wire logic [MEM_AW-1:0] addr,
    output pmm_region_type         region,
    output logic [MEM_AW-1:0]      bootEnd
);
    logic [MEM_AW-1:0] storeStart;

    always_comb begin
        // size code to end address, clamped to half of flash
        case (partCfg[2:0])
            3'b111:  bootEnd = BOOT_END_111;
            3'b110:  bootEnd = BOOT_END_110;
            3'b101:  bootEnd = BOOT_END_101;
            3'b100:  bootEnd = BOOT_END_100;
            3'b011:  bootEnd = BOOT_END_011;
            default: bootEnd = HALF_END;
        endcase
        storeStart = LAST_ADDR - STORAGE_WORDS + 14'h0001;
        if (!partCfg[PART_BOOT_BIT] && addr <= bootEnd) begin
            region = PMM_REG_BOOT;
        end else if (!partCfg[PART_STOR_BIT] && addr >= storeStart) begin
            region = PMM_REG_STORE;
        end else begin
            region = PMM_REG_APP;
        end
    end
endmodule

// ---- hw/pmm_indirect.sv ----
/*
 indirect pointer access into program memory with two added stall cycles.
 assumes the data-side program memory port answers one cycle after its address.
*/
`timescale 1ns/100ps
module pmm_indirect
    import pmm_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              srst,
    input  wire logic              reqValid,
    input  wire logic              reqWrite,
    input  wire logic [7:0]        ptrHigh,
    input  wire logic [7:0]        ptrLow,
    input  wire logic [WORD_W-1:0] memRdata,
    output logic [MEM_AW-1:0]      memAddr,
    output logic                   stall,
    output logic [7:0]             rdata,
    output logic                   done,
    output logic                   writeDropped
);
    typedef enum logic [1:0] {PMM_IDLE, PMM_WAIT, PMM_TAKE} pmm_ind_type;

    pmm_ind_type       state_q, state_d;
    logic [MEM_AW-1:0] addr_q, addr_d;
    logic [7:0]        data_q, data_d;
    logic              stall_q, stall_d;
    logic              done_q, done_d;
    logic              drop_q, drop_d;
    logic              progHit;

    assign progHit = reqValid && ptrHigh[PTR_PROG_BIT];

    always_comb begin
        state_d = state_q;
        addr_d  = addr_q;
        data_d  = data_q;
        stall_d = 1'b0;
        done_d  = 1'b0;
        drop_d  = 1'b0;
        case (state_q)
            PMM_IDLE: begin
                if (progHit && reqWrite) begin
                    drop_d = 1'b1;
                end else if (progHit) begin
                    addr_d  = {ptrHigh[5:0], ptrLow};
                    stall_d = 1'b1;
                    state_d = PMM_WAIT;
                end
            end
            PMM_WAIT: begin
                stall_d = 1'b1;
                state_d = PMM_TAKE;
            end
            PMM_TAKE: begin
                data_d  = memRdata[7:0];
                done_d  = 1'b1;
                state_d = PMM_IDLE;
            end
            default: state_d = PMM_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state_q <= PMM_IDLE;
            addr_q  <= '0;
            data_q  <= 8'h00;
            stall_q <= 1'b0;
            done_q  <= 1'b0;
            drop_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            addr_q  <= addr_d;
            data_q  <= data_d;
            stall_q <= stall_d;
            done_q  <= done_d;
            drop_q  <= drop_d;
        end
    end

    assign memAddr      = addr_q;
    assign stall        = stall_q;
    assign rdata        = data_q;
    assign done         = done_q;
    assign writeDropped = drop_q;
endmodule

// ---- verif/pmm_prog_mem_model.sv ----
/*
 data-side program memory model for the indirect port.
 assumes the address comes from the block and the word is due one cycle later.
*/
`timescale 1ns/100ps
module pmm_prog_mem_model
    import pmm_pkg::*;
(
    input  wire logic [0:0]        clk_sys,
    input  wire logic [MEM_AW-1:0] addr,
    output logic [WORD_W-1:0]      rdata
);
    // own data-side port beside the fetch path
    // read-only content, inverted address; no write port
    always_ff @(posedge clk_sys) begin
        rdata <= ~addr;
    end
endmodule

// ---- verif/pmm_map_top_properties.sv ----
/*
 concurrent checks on the program memory map block.
 assumes only the ports of pmm_map_top, one clock, synchronous reset.
*/
`timescale 1ns/100ps
module pmm_map_top_properties
    import pmm_pkg::*;
#(
    parameter logic [11:0] PART_CODE  = 12'h0A5,
    parameter logic [5:0]  MAJOR_STEP = 6'h01,
    parameter logic [5:0]  MINOR_STEP = 6'h00
)
(
    input wire logic              clk_sys,
    input wire logic              srst,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              coreAdvance,
    input wire logic              coreLoad,
    input wire logic              irqTake,
    input wire logic [PC_W-1:0]   pcValue,
    input wire logic [MEM_AW-1:0] fetchAddr,
    input wire logic [1:0]        fetchRegion,
    input wire logic              execViolation,
    input wire logic              dataReq,
    input wire logic              dataWrite,
    input wire logic [7:0]        indirectPointerHigh,
    input wire logic [WORD_W-1:0] dataMemRdata,
    input wire logic [7:0]        indirectDataPort,
    input wire logic              dataDone,
    input wire logic              dataStall,
    input wire logic              writeDropped
);
    logic [7:0] memLow_q;
    logic       idle;
    always_ff @(posedge clk_sys) begin
        memLow_q <= dataMemRdata[7:0];
    end
    assign idle = indirectPointerHigh[7] && !dataStall && !dataDone;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    property p_ident;
        psel && penable && pready && !pwrite && paddr == 18'h20018
            |-> prdata == {18'h0, 2'b11, PART_CODE};
    endproperty
    a_ident: assert property (p_ident) else $error("identity word wrong");
    property p_rev;
        psel && penable && pready && !pwrite && paddr == 18'h20014
            |-> prdata == {18'h0, 2'b10, MAJOR_STEP, MINOR_STEP};
    endproperty
    a_rev: assert property (p_rev) else $error("revision word wrong");
    property p_step;
        coreAdvance && !coreLoad && !irqTake && !dataStall
            |=> pcValue == $past(pcValue) + 15'h0001;
    endproperty
    a_step: assert property (p_step) else $error("counter step wrong");
    property p_wrap;
        fetchAddr == pcValue[13:0];
    endproperty
    a_wrap: assert property (p_wrap) else $error("fetch address not wrapped");
    property p_irq;
        irqTake |=> pcValue == IRQ_VECTOR;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt vector wrong");
    property p_rstvec;
        $fell(srst) |-> pcValue == RESET_VECTOR;
    endproperty
    a_rstvec: assert property (p_rstvec) else $error("reset vector wrong");
    property p_read;
        dataReq && !dataWrite && idle |=> dataStall [*2] ##1 (!dataStall && dataDone);
    endproperty
    a_read: assert property (p_read) else $error("indirect read timing wrong");
    property p_byte;
        dataDone |-> indirectDataPort == memLow_q;
    endproperty
    a_byte: assert property (p_byte) else $error("indirect byte wrong");
    property p_drop;
        dataReq && dataWrite && idle |=> writeDropped && !dataStall && !dataDone;
    endproperty
    a_drop: assert property (p_drop) else $error("indirect write not dropped");
    property p_viol;
        (execViolation == (fetchRegion == 2'd2)) && (!execViolation || fetchAddr >= 14'h3F80);
    endproperty
    a_viol: assert property (p_viol) else $error("storage execution flag wrong");
endmodule

bind pmm_map_top pmm_map_top_properties #(
    .PART_CODE(PART_CODE),
    .MAJOR_STEP(MAJOR_STEP),
    .MINOR_STEP(MINOR_STEP)
) u_props (.*);

// ---- verif/pmm_map_top_tb.sv ----
/*
 self-checking bench for the program memory map block.
 assumes the data-side memory model and the bound checker.
*/
`timescale 1ns/100ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_mismatch++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module pmm_map_top_tb
    import pmm_pkg::*;
;
    localparam logic [11:0] PCODE = 12'h3C6;  // arbitrary value
    localparam logic [5:0]  MAJ   = 6'h02;    // arbitrary value
    localparam logic [5:0]  MIN   = 6'h07;    // arbitrary value
    localparam logic [13:0] ENDS [8] = '{14'h1FFF, 14'h1FFF, 14'h1FFF, 14'h1FFF,
                                         14'h0FFF, 14'h07FF, 14'h03FF, 14'h01FF};
    logic        clk_sys, srst, psel, penable, pwrite, pready, pslverr, err;
    logic [17:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        coreAdvance, coreLoad, irqTake, execViolation;
    logic [14:0] coreLoadAddr, pcValue;
    logic [13:0] fetchAddr, dataMemAddr, dataMemRdata;
    logic [1:0]  fetchRegion;
    logic        dataReq, dataWrite, dataDone, dataStall, writeDropped;
    logic [7:0]  indirectPointerHigh, indirectPointerLow, indirectDataPort;
    int          n_mismatch, n_compared;

    pmm_map_top #(.PART_CODE(PCODE), .MAJOR_STEP(MAJ), .MINOR_STEP(MIN)) uut (.*);
    pmm_prog_mem_model mem (.clk_sys(clk_sys), .addr(dataMemAddr), .rdata(dataMemRdata));

    task automatic close_out;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] d);
        int i;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge clk_sys);
            i++;
        end while (pready !== 1'b1 && i < 20);
        if (i >= 20) begin
            n_mismatch++;
            close_out();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic pulse(input logic a, input logic l, input logic q, input logic [14:0] t);
        @(posedge clk_sys);
        coreAdvance <= a;
        coreLoad <= l;
        irqTake <= q;
        coreLoadAddr <= t;
        @(posedge clk_sys);
        coreAdvance <= 1'b0;
        coreLoad <= 1'b0;
        irqTake <= 1'b0;
        #1;
    endtask

    task automatic ind(input logic w, input logic [7:0] hi, input logic [7:0] lo);
        int i;
        @(posedge clk_sys);
        dataReq <= 1'b1;
        dataWrite <= w;
        indirectPointerHigh <= hi;
        indirectPointerLow <= lo;
        @(posedge clk_sys);
        dataReq <= 1'b0;
        i = 0;
        do begin
            @(posedge clk_sys);
            i++;
        end while ((w ? writeDropped : dataDone) !== 1'b1 && i < 10);
        if (i >= 10) begin
            n_mismatch++;
            close_out();
        end
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    initial begin
        {srst, psel, penable, pwrite, coreAdvance, coreLoad, irqTake} = 7'h7F;
        {psel, penable, pwrite, coreAdvance, coreLoad, irqTake, dataReq, dataWrite} = 8'h00;
        {paddr, pwdata, coreLoadAddr, indirectPointerHigh, indirectPointerLow} = '0;
        n_mismatch = 0;
        n_compared = 0;
        repeat (5) @(posedge clk_sys);
        srst <= 1'b0;
        #1;
        `CHK(pcValue, RESET_VECTOR)
        pulse(1, 0, 0, 0); `CHK(pcValue, 15'h0001)
        pulse(1, 1, 1, 15'h1234); `CHK(pcValue, IRQ_VECTOR)
        pulse(0, 1, 0, 15'h7FFF); pulse(1, 0, 0, 0); `CHK(pcValue, 15'h0000)
        pulse(0, 1, 0, 15'h4ABC); `CHK(fetchAddr, 14'h0ABC)
        $display("test counter done");
        apb(0, IDX_IDENTITY, 0); `CHK(rd, {18'h0, 2'b11, PCODE})
        apb(1, IDX_IDENTITY, 32'hFFFFFFFF); apb(1, IDX_REVISION, 32'h0);
        apb(0, IDX_IDENTITY, 0); `CHK(rd, {18'h0, 2'b11, PCODE})
        apb(0, IDX_REVISION, 0); `CHK(rd, {18'h0, 2'b10, MAJ, MIN})
        apb(0, 16'h8001, 0); `CHK(err, 1'b1)
        apb(0, IDX_PARTITION, 0); `CHK(rd, 32'h0000001F)
        $display("test identity done");
        pulse(0, 1, 0, 15'h3FFF); `CHK(fetchRegion, 2'd0)
        for (int c = 7; c >= 0; c--) begin
            apb(1, IDX_PARTITION, {27'h0, 2'b10, 3'(c)});
            pulse(0, 1, 0, {1'b0, ENDS[c]}); `CHK(fetchRegion, 2'd1)
            pulse(0, 1, 0, {1'b0, ENDS[c] + 14'h1}); `CHK(fetchRegion, 2'd0)
        end
        pulse(0, 1, 0, 15'h0000); `CHK(fetchRegion, 2'd1)
        apb(1, IDX_PARTITION, 32'h0000000F);
        pulse(0, 1, 0, 15'h7F80); `CHK({fetchRegion, execViolation}, 3'b101)
        pulse(0, 1, 0, 15'h3F7F); `CHK({fetchRegion, execViolation}, 3'b000)
        apb(0, IDX_STATUS, 0); `CHK(rd, {14'h01FF, 2'b00, 1'b0, 15'h3F7F})
        $display("test partition done");
        ind(0, 8'h81, 8'h23); `CHK(indirectDataPort, 8'hDC)
        ind(1, 8'h81, 8'h00); `CHK(indirectDataPort, 8'hDC)
        ind(0, 8'hBF, 8'hFF); `CHK(dataMemAddr, 14'h3FFF)
        `CHK(indirectDataPort, 8'h00)
        $display("test indirect done");
        close_out();
    end
endmodule
